//--- design/maf_filter.sv
// moving-average filter with sequence counter and byte-wide host exchange
// assumes converter results arrive on clk; host pins are asynchronous
//
// Overview of operation
// - new sample replaces oldest, mean becomes result
// - depth 1 passes raw sample through
// - depth 2 averages current and previous sample
// - depth 4 averages four newest samples
// - depth 8 averages eight newest samples
// - only depths 1, 2, 4, 8 accepted
// - invalid depth stores 1 instead
// - set-filter writes validated depth to storage
// - get-filter returns stored depth
// - byte counter increments once per result
// - counter wraps 255 to 0
// - count read returns counter byte only
// - raw read returns three raw sample bytes, then a status byte
`timescale 1ns/1ps
`include "maf_defines.svh"

module maf_filter
	import maf_pkg::*;
#(
	parameter int SAMPLE_W   = 24,
	parameter int HIST_DEPTH = 8
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// converter results, same clock
	input  wire logic                sampleValid,
	input  wire logic [SAMPLE_W-1:0] sampleData,
	// host pins
	input  wire maf_host_in_t        hostIn,
	output logic [7:0]               hostOutData,
	output logic                     inputBufferFull,
	output logic                     outputBufferFull,
	// filter state
	output logic [SAMPLE_W-1:0]      filteredResult,
	output logic                     filteredValid,
	output logic [7:0]               seqCount,
	output logic [7:0]               filterDepth
);
	localparam int IDX_W = $clog2(HIST_DEPTH);
	localparam int SUM_W = SAMPLE_W + IDX_W;
	typedef logic [SAMPLE_W-1:0] maf_hist_t [HIST_DEPTH];

	function automatic logic depthOk(input logic [7:0] d);
		return (d == `MAF_DEPTH_1) || (d == `MAF_DEPTH_2) ||
			(d == `MAF_DEPTH_4) || (d == `MAF_DEPTH_8);
	endfunction : depthOk

	function automatic logic [1:0] depthShift(input logic [7:0] d);
		case (d)
			`MAF_DEPTH_2: return 2'h1;
			`MAF_DEPTH_4: return 2'h2;
			`MAF_DEPTH_8: return 2'h3;
			default:      return 2'h0;
		endcase
	endfunction : depthShift

	function automatic logic [SUM_W-1:0] windowSum(input maf_hist_t h,
			input logic [IDX_W-1:0] idx, input logic [SAMPLE_W-1:0] s,
			input logic [7:0] d);
		logic [SUM_W-1:0] acc;
		acc = SUM_W'(s);
		for (int k = 1; k < HIST_DEPTH; k++) begin
			if (k < int'(d))
				acc = acc + SUM_W'(h[idx - IDX_W'(k)]);
		end
		return acc;
	endfunction : windowSum

	// host pin synchroniser: stage one feeds stage two only
	maf_host_in_t hostS1, hostS2, hostS3, hostLvl, hostPrev;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hostS1   <= '0;
			hostS2   <= '0;
			hostS3   <= '0;
			hostLvl  <= '0;
			hostPrev <= '0;
		end else begin
			hostS1   <= hostIn;
			hostS2   <= hostS1;
			hostS3   <= hostS2;
			if (hostS2 == hostS3)
				hostLvl <= hostS3;
			hostPrev <= hostLvl;
		end
	end
	logic wrCmdEdge, wrDatEdge, rdAckEdge;
	assign wrCmdEdge = hostLvl.wrCmd & ~hostPrev.wrCmd;
	assign wrDatEdge = hostLvl.wrDat & ~hostPrev.wrDat;
	assign rdAckEdge = hostLvl.rdAck & ~hostPrev.rdAck;

	// host exchange state
	maf_state_t  state, next_state;
	logic        next_ibf, next_obf, inIsCmd, next_inIsCmd;
	logic [7:0]  inByte, next_inByte, next_outByte, next_depth;
	logic [31:0] respBuf, next_respBuf;
	logic [2:0]  respLeft, next_respLeft;
	logic        depthWrite, consume;
	logic [SAMPLE_W-1:0] rawSample, next_raw;

	always_comb begin
		next_state    = state;
		next_inByte   = inByte;
		next_inIsCmd  = inIsCmd;
		next_outByte  = hostOutData;
		next_depth    = filterDepth;
		next_respBuf  = respBuf;
		next_respLeft = respLeft;
		depthWrite    = 1'b0;
		consume       = inputBufferFull && (state != ST_REPLY);
		if (consume) begin
			next_state    = ST_REPLY;
			next_respLeft = 3'h1;
			next_respBuf  = {24'h000000, `MAF_INVALID_ERROR};
			if (state == ST_WAIT_DEPTH && !inIsCmd) begin
				next_depth   = depthOk(inByte) ? inByte : `MAF_DEPTH_1;
				depthWrite   = 1'b1;
				next_respBuf = {24'h000000, `MAF_SUCCESS_CODE};
			end else if (state == ST_IDLE && inIsCmd) begin
				case (inByte)
					`MAF_CMD_SET_FILTER: begin
						next_state    = ST_WAIT_DEPTH;
						next_respLeft = 3'h0;
					end
					`MAF_CMD_GET_FILTER: begin
						next_respLeft = 3'h2;
						next_respBuf  = {16'h0000, `MAF_SUCCESS_CODE, filterDepth};
					end
					`MAF_CMD_GET_COUNT: begin
						next_respBuf = {24'h000000, seqCount};
					end
					`MAF_CMD_READ_RAW: begin
						next_respLeft = 3'h4;
						next_respBuf  = {`MAF_SUCCESS_CODE, 24'(rawSample)};
					end
					`MAF_CMD_READ_WEIGHT: begin
						next_respLeft = 3'h4;
						next_respBuf  = {`MAF_SUCCESS_CODE, 24'(filteredResult)};
					end
					default: begin
					end
				endcase
			end
		end
		next_obf = outputBufferFull & ~rdAckEdge;
		if (state == ST_REPLY) begin
			if (respLeft == 3'h0) begin
				next_state = ST_IDLE;
			end else if (!outputBufferFull) begin
				next_outByte  = respBuf[7:0];
				next_respBuf  = {8'h00, respBuf[31:8]};
				next_respLeft = respLeft - 3'h1;
				next_obf      = 1'b1;
			end
		end
		// a host write sets the flag even while it is consumed
		next_ibf = inputBufferFull & ~consume;
		if (wrCmdEdge || wrDatEdge) begin
			next_ibf     = 1'b1;
			next_inByte  = hostLvl.data;
			next_inIsCmd = wrCmdEdge;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state            <= ST_IDLE;
			inputBufferFull  <= 1'b0;
			outputBufferFull <= 1'b0;
			inByte           <= 8'h00;
			inIsCmd          <= 1'b0;
			hostOutData      <= 8'h00;
			filterDepth      <= `MAF_DEPTH_RESET;
			respBuf          <= 32'h00000000;
			respLeft         <= 3'h0;
		end else begin
			state            <= next_state;
			inputBufferFull  <= next_ibf;
			outputBufferFull <= next_obf;
			inByte           <= next_inByte;
			inIsCmd          <= next_inIsCmd;
			hostOutData      <= next_outByte;
			filterDepth      <= next_depth;
			respBuf          <= next_respBuf;
			respLeft         <= next_respLeft;
		end
	end

	// filter datapath
	maf_hist_t hist, next_hist, baseHist;
	logic [IDX_W-1:0]    wrIdx, next_wrIdx, baseIdx;
	logic [SAMPLE_W-1:0] next_filtered;
	logic [7:0]          next_seq;
	logic                next_fValid;

	always_comb begin
		// depth change restarts from an empty history
		baseHist      = hist;
		baseIdx       = wrIdx;
		if (depthWrite) begin
			baseHist = '{default: '0};
			baseIdx  = '0;
		end
		next_hist     = baseHist;
		next_wrIdx    = baseIdx;
		next_raw      = rawSample;
		next_filtered = filteredResult;
		next_fValid   = 1'b0;
		next_seq      = seqCount;
		if (sampleValid) begin
			next_hist[baseIdx] = sampleData;
			next_wrIdx         = baseIdx + IDX_W'(1);
			next_raw           = sampleData;
			next_filtered = SAMPLE_W'(windowSum(baseHist, baseIdx, sampleData, next_depth)
				>> depthShift(next_depth));
			next_fValid   = 1'b1;
			next_seq      = seqCount + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hist           <= '{default: '0};
			wrIdx          <= '0;
			rawSample      <= '0;
			filteredResult <= '0;
			filteredValid  <= 1'b0;
			seqCount       <= `MAF_SEQ_RESET;
		end else begin
			hist           <= next_hist;
			wrIdx          <= next_wrIdx;
			rawSample      <= next_raw;
			filteredResult <= next_filtered;
			filteredValid  <= next_fValid;
			seqCount       <= next_seq;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence cmdTaken(logic [7:0] code);
		consume && state == ST_IDLE && inIsCmd && inByte == code;
	endsequence
	sequence replyOf(logic [2:0] n);
		state == ST_REPLY && respLeft == n;
	endsequence

	seqStep_a: assert property (filteredValid |-> seqCount == 8'($past(seqCount) + 8'h01))
		else $error("sequence counter did not step once");
	seqWrap_a: assert property (filteredValid && $past(seqCount) == 8'hFF |-> seqCount == 8'h00)
		else $error("sequence counter did not wrap");
	passThrough_a: assert property (filteredValid && filterDepth == `MAF_DEPTH_1 |->
		filteredResult == $past(sampleData))
		else $error("depth one result differs from sample");
	depthLegal_a: assert property (depthOk(filterDepth))
		else $error("stored depth not legal");
	depthStore_a: assert property (depthWrite |=> filterDepth ==
		(depthOk($past(inByte)) ? $past(inByte) : `MAF_DEPTH_1))
		else $error("validated depth not stored");
	countReply_a: assert property (cmdTaken(`MAF_CMD_GET_COUNT) |=> replyOf(3'h1) ##0
		respBuf[7:0] == $past(seqCount))
		else $error("count reply not a single counter byte");
	rawReply_a: assert property (cmdTaken(`MAF_CMD_READ_RAW) |=> replyOf(3'h4) ##0
		respBuf[23:0] == 24'($past(rawSample)))
		else $error("raw reply not three bytes plus status");
	getDepth_a: assert property (cmdTaken(`MAF_CMD_GET_FILTER) |=> replyOf(3'h2) ##0
		respBuf[7:0] == $past(filterDepth))
		else $error("depth reply wrong");
	histClear_a: assert property (depthWrite && !sampleValid |=> wrIdx == '0 && hist[0] == '0)
		else $error("history not cleared on depth change");
	histWrite_a: assert property (sampleValid && !depthWrite |=>
		hist[$past(wrIdx)] == $past(sampleData))
		else $error("sample not written over oldest slot");
endmodule : maf_filter

//--- include/maf_defines.svh
// constants of the moving-average filter: command codes, reply codes, reset values
// assumes inclusion under this guard by the package, the filter module and the bench
`ifndef MAF_DEFINES_SVH
`define MAF_DEFINES_SVH

// host command bytes
`define MAF_CMD_SET_FILTER   8'h01
`define MAF_CMD_GET_FILTER   8'h02
`define MAF_CMD_GET_COUNT    8'h03
`define MAF_CMD_READ_RAW     8'h04
`define MAF_CMD_READ_WEIGHT  8'h05

// reply status bytes
`define MAF_SUCCESS_CODE     8'h00
`define MAF_INVALID_ERROR    8'h01

// depth settings and reset values
`define MAF_DEPTH_1          8'h01
`define MAF_DEPTH_2          8'h02
`define MAF_DEPTH_4          8'h04
`define MAF_DEPTH_8          8'h08
`define MAF_DEPTH_RESET      8'h01
`define MAF_SEQ_RESET        8'h00

`endif

//--- include/maf_pkg.sv
// types shared by the moving-average filter and its bench
// assumes maf_defines.svh on the include path
package maf_pkg;
	`include "maf_defines.svh"

	// host pins of the byte-wide command/data/status exchange
	typedef struct packed {
		logic       wrCmd;
		logic       wrDat;
		logic       rdAck;
		logic [7:0] data;
	} maf_host_in_t;

	typedef enum logic [1:0] {
		ST_IDLE       = 2'b00,
		ST_WAIT_DEPTH = 2'b01,
		ST_REPLY      = 2'b10
	} maf_state_t;
endpackage : maf_pkg

//--- testbench/maf_host_model.sv
// host side of the byte exchange: command/data writes and reply byte reads
// assumes a free-running clk; every task is entered from the bench just after a clk edge
`timescale 1ns/1ps

module maf_host_model
	import maf_pkg::*;
(
	// clock
	input  wire logic       clk,
	// device side
	input  wire logic       inputBufferFull,
	input  wire logic       outputBufferFull,
	input  wire logic [7:0] hostOutData,
	// host pins
	output maf_host_in_t    hostIn,
	output logic            timedOut
);
	initial begin
		hostIn = '0;
		timedOut = 1'b0;
	end

	// bounded wait on one of the buffer flags; a miss is flagged, never hangs
	task automatic waitFlag(input logic isOut, input logic want);
		int n;
		n = 0;
		while (((isOut ? outputBufferFull : inputBufferFull) !== want) && n < 80) begin
			@(posedge clk);
			n++;
		end
		if (n >= 80)
			timedOut <= 1'b1;
	endtask : waitFlag

	task automatic writeByte(input logic isCmd, input logic [7:0] b);
		waitFlag(1'b0, 1'b0);
		@(posedge clk);
		hostIn.data <= b;
		@(posedge clk);
		if (isCmd)
			hostIn.wrCmd <= 1'b1;
		else
			hostIn.wrDat <= 1'b1;
		repeat (6) @(posedge clk);
		hostIn.wrCmd <= 1'b0;
		hostIn.wrDat <= 1'b0;
		repeat (4) @(posedge clk);
		// released bus shows the inverse so a stale byte cannot pass as held
		hostIn.data <= ~b;
	endtask : writeByte

	task automatic readByte(output logic [7:0] b);
		waitFlag(1'b1, 1'b1);
		b = hostOutData;
		hostIn.rdAck <= 1'b1;
		waitFlag(1'b1, 1'b0);
		@(posedge clk);
		hostIn.rdAck <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : readByte
endmodule : maf_host_model

//--- testbench/maf_filter_test.sv
// self-checking bench of the moving-average filter
// assumes the host model file and maf_defines.svh on the include path
`timescale 1ns/1ps
`include "maf_defines.svh"

module maf_filter_test
	import maf_pkg::*;
;
	logic clk, arst_n, sampleValid, inputBufferFull, outputBufferFull, filteredValid, timedOut;
	logic [23:0] sampleData, filteredResult, lastRaw, lastFilt;
	logic [7:0] hostOutData, seqCount, filterDepth, expSeq;
	logic [23:0] hist [8];
	logic [31:0] r;
	maf_host_in_t hostIn;
	int badCount, samplesChecked, cycles, depth;

	maf_filter maf_filter_i (.clk(clk), .arst_n(arst_n), .sampleValid(sampleValid),
		.sampleData(sampleData), .hostIn(hostIn), .hostOutData(hostOutData),
		.inputBufferFull(inputBufferFull), .outputBufferFull(outputBufferFull),
		.filteredResult(filteredResult), .filteredValid(filteredValid),
		.seqCount(seqCount), .filterDepth(filterDepth));
	maf_host_model maf_host_model_i (.clk(clk), .inputBufferFull(inputBufferFull),
		.outputBufferFull(outputBufferFull), .hostOutData(hostOutData),
		.hostIn(hostIn), .timedOut(timedOut));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			badCount++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tallyAndFinish

	// reply bytes arrive low byte first
	task automatic reply(input logic [7:0] cmd, input int n);
		logic [7:0] b;
		maf_host_model_i.writeByte(1'b1, cmd);
		r = '0;
		for (int i = 0; i < n; i++) begin
			maf_host_model_i.readByte(b);
			r[8*i +: 8] = b;
		end
	endtask : reply

	task automatic feed(input logic [23:0] d);
		logic [26:0] sum;
		int sh;
		@(posedge clk);
		sampleValid <= 1'b1;
		sampleData <= d;
		for (int i = 7; i > 0; i--)
			hist[i] = hist[i-1];
		hist[0] = d;
		sum = '0;
		for (int i = 0; i < depth; i++)
			sum += 27'(hist[i]);
		sh = (depth == 8) ? 3 : (depth == 4) ? 2 : (depth == 2) ? 1 : 0;
		lastRaw = d;
		lastFilt = 24'(sum >> sh);
		expSeq++;
		@(posedge clk);
		sampleValid <= 1'b0;
		sampleData <= ~d;
		#1;
		check("filteredValid", 32'(filteredValid), 32'h1);
		check("filteredResult", 32'(filteredResult), 32'(lastFilt));
		check("seqCount", 32'(seqCount), 32'(expSeq));
	endtask : feed

	task automatic setDepth(input logic [7:0] v);
		logic [7:0] exp;
		exp = (v == 8'h01 || v == 8'h02 || v == 8'h04 || v == 8'h08) ? v : 8'h01;
		maf_host_model_i.writeByte(1'b1, `MAF_CMD_SET_FILTER);
		maf_host_model_i.writeByte(1'b0, v);
		maf_host_model_i.readByte(r[7:0]);
		check("setReply", 32'(r[7:0]), 32'(`MAF_SUCCESS_CODE));
		check("filterDepth", 32'(filterDepth), 32'(exp));
		reply(`MAF_CMD_GET_FILTER, 2);
		check("getReply", r, 32'(exp));
		depth = int'(exp);
		// fresh history after a depth write
		foreach (hist[i])
			hist[i] = '0;
	endtask : setDepth

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			badCount++;
			tallyAndFinish();
		end
	end

	initial begin
		logic [7:0] depths [8];
		depths = '{8'h02, 8'h04, 8'h08, 8'h01, 8'h03, 8'hFF, 8'h00, 8'h08};
		arst_n = 1'b0;
		sampleValid = 1'b0;
		sampleData = '0;
		{badCount, samplesChecked, cycles} = '0;
		expSeq = '0;
		depth = 1;
		foreach (hist[i])
			hist[i] = '0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		check("resetDepth", 32'(filterDepth), 32'h1);
		check("resetSeq", 32'(seqCount), 32'h0);
		feed(24'h00F00D);
		foreach (depths[k]) begin
			setDepth(depths[k]);
			for (int i = 0; i < 10; i++)
				feed(24'h123457 + 24'(i * 24'h0F0F0F) + 24'(k));
		end
		// enough results to carry the count past 255
		for (int i = 0; i < 200; i++)
			feed(24'hFFFFFF - 24'(i * 24'h01A2B3));
		reply(`MAF_CMD_GET_COUNT, 1);
		check("countReply", r, 32'(expSeq));
		repeat (10) @(posedge clk);
		check("noTrailer", 32'(outputBufferFull), 32'h0);
		feed(24'hABCDEF);
		reply(`MAF_CMD_GET_COUNT, 1);
		check("countChanged", r, 32'(expSeq));
		reply(`MAF_CMD_READ_RAW, 4);
		check("rawReply", r, {8'h00, lastRaw});
		reply(`MAF_CMD_READ_WEIGHT, 4);
		check("weightReply", r, {8'h00, lastFilt});
		reply(8'h07, 1);
		check("badCmd", r, 32'(`MAF_INVALID_ERROR));
		maf_host_model_i.writeByte(1'b0, 8'h55);
		maf_host_model_i.readByte(r[7:0]);
		check("strayData", 32'(r[7:0]), 32'(`MAF_INVALID_ERROR));
		// mid-run reset: nothing of depth, count or history survives it
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		check("midResetDepth", 32'(filterDepth), 32'h1);
		check("midResetSeq", 32'(seqCount), 32'h0);
		depth = 1;
		expSeq = '0;
		foreach (hist[i])
			hist[i] = '0;
		feed(24'h0BEEF0);
		check("hostTimeout", 32'(timedOut), 32'h0);
		tallyAndFinish();
	end
endmodule : maf_filter_test
